// ### ccd_pkg.sv
// Decoder constants and types
package ccd_pkg;
  // Framing bytes, request length limit
  localparam logic [7:0] BYTE_STX    = 8'h02;
  localparam logic [7:0] BYTE_ETX    = 8'h03;
  localparam logic [7:0] BYTE_EOT    = 8'h04;
  localparam logic [7:0] REQ_LEN_MAX = 8'h20;
  // Command codes, message lengths
  localparam logic [7:0] CMD_ERROR   = 8'h00;
  localparam logic [7:0] CMD_READ    = 8'h01;
  localparam logic [7:0] CMD_CALMODE = 8'h04;
  localparam logic [7:0] CMD_CALSET  = 8'h12;
  localparam logic [7:0] CMD_CALIB   = 8'h13;
  localparam logic [7:0] CALMODE_KEY = 8'h55;
  localparam logic [7:0] LEN_FLOAT   = 8'h05;
  localparam logic [7:0] LEN_SHORT   = 8'h02;
  localparam logic [7:0] LEN_LONG    = 8'h03;
  localparam logic [7:0] LEN_ERR     = 8'h02;
  localparam logic [7:0] READ_BYTES  = 8'h05;
  localparam logic [7:0] CALSEL_MAX  = 8'h03;
  // Error numbers; ERR_NONE is internal only
  localparam logic [7:0] ERR_CSUM    = 8'h00;
  localparam logic [7:0] ERR_LEN     = 8'h01;
  localparam logic [7:0] ERR_PARAM   = 8'h02;
  localparam logic [7:0] ERR_FLASH   = 8'h03;
  localparam logic [7:0] ERR_UNSUP   = 8'h04;
  localparam logic [7:0] ERR_OTHER   = 8'h05;
  localparam logic [7:0] ERR_MEM_ABS = 8'h06;
  localparam logic [7:0] ERR_MEM_BSY = 8'h07;
  localparam logic [7:0] ERR_NONE    = 8'hFF;
  // Selector words, cal modes
  localparam logic [31:0] SEL_MEASURE = 32'h00000000;
  localparam logic [31:0] SEL_CYCLE   = 32'h3F800000;
  localparam logic [31:0] SEL_ZERO    = 32'h40000000;
  localparam logic [31:0] SEL_SPAN    = 32'h40400000;
  localparam logic [1:0] CAL_MEASURE = 2'h0;
  localparam logic [1:0] CAL_CYCLE   = 2'h1;
  localparam logic [1:0] CAL_ZERO    = 2'h2;
  localparam logic [1:0] CAL_SPAN    = 2'h3;
  // Sub-commands, run modes, purge operations
  localparam logic [7:0] SUB_MODE  = 8'h01;
  localparam logic [7:0] SUB_PURGE = 8'h02;
  localparam logic [7:0] SUB_PORT  = 8'h03;
  localparam logic [7:0] SUB_STD   = 8'h04;
  localparam logic [1:0] RUN_STOP  = 2'h0;
  localparam logic [1:0] RUN_IDLE  = 2'h1;
  localparam logic [1:0] RUN_POINT = 2'h2;
  localparam logic [1:0] RUN_SEQ   = 2'h3;
  localparam logic [2:0] PURGE_STOP   = 3'h0;
  localparam logic [2:0] PURGE_NOW    = 3'h1;
  localparam logic [2:0] PURGE_TIMED  = 3'h2;
  localparam logic [2:0] PURGE_OFF    = 3'h3;
  localparam logic [2:0] PURGE_CHANGE = 3'h4;
  localparam logic [2:0] PURGE_START  = 3'h5;
  localparam logic [7:0] PURGE_TIME_MAX = 8'h0F;
  // Index limits
  localparam logic [7:0] GAS_MAX   = 8'h1C;
  localparam logic [7:0] UNIT_MAX  = 8'h03;
  localparam logic [7:0] PORT_MAX  = 8'h0A;
  localparam logic [7:0] PORT_SRC  = 8'h03;
  localparam logic [7:0] STD_MAX   = 8'h0A;
  localparam logic [7:0] POINT_MAX = 8'h20;
  localparam logic [7:0] SEQ_MAX   = 8'h10;
  localparam logic [7:0] DAY_MAX   = 8'h1F;
  localparam logic [7:0] MONTH_MAX = 8'h0C;
  localparam logic [7:0] YEAR_MAX  = 8'h3F;
  localparam logic [7:0] STD_LEN_MIN = 8'h18;
  localparam logic [7:0] STD_LEN_MAX = 8'h36;
  localparam logic [7:0] STD_STEP    = 8'h06;
  // Standard field positions (byte n at n-1)
  localparam logic [4:0] POS_DAY   = 5'h0E;
  localparam logic [4:0] POS_MONTH = 5'h0F;
  localparam logic [4:0] POS_YEAR  = 5'h10;
  localparam logic [4:0] POS_BAL   = 5'h11;
  localparam logic [4:0] POS_GAS   = 5'h12;
  localparam logic [4:0] POS_UNIT  = 5'h13;
  localparam logic [4:0] POS_CONC  = 5'h14;
  // APB offsets, reset values
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_CALVAL  = 8'h08;
  localparam logic [7:0] REG_CALSEL  = 8'h0C;
  localparam logic [7:0] REG_STD     = 8'h10;
  localparam logic [7:0] REG_STDCONC = 8'h14;
  localparam logic [7:0] REG_PORTSEL = 8'h18;
  localparam logic [7:0] REG_PORTATT = 8'h1C;
  localparam logic [7:0] RST_NODE_ID = 8'h00;

  typedef enum logic [4:0] {
    ST_STX, ST_ID, ST_CMD, ST_ETX, ST_LEN, ST_MSG, ST_SUM, ST_EOT,
    ST_EXEC, TX_STX, TX_ID, TX_CMD, TX_ETX, TX_LEN, TX_MSG, TX_SUM,
    TX_EOT
  } ccd_st_t;

  typedef struct packed {
    logic [1:0] run_mode;
    logic [7:0] func;
    logic [1:0] cal_mode;
    logic [2:0] purge_mode;
    logic [7:0] purge_time;
  } ccd_run_t;

  typedef struct packed {
    ccd_st_t          st;
    logic [7:0]       cmd;
    logic [7:0]       len;
    logic [7:0]       cnt;
    logic [7:0]       sum;
    logic             sum_ok;
    logic             id_ok;
    logic [31:0][7:0] msg;
    logic [7:0]       rsp_cmd;
    logic [7:0]       rsp_len;
    logic [7:0]       err_code;
    logic             rd;
    logic [4:0]       k;
    logic [2:0]       sub;
    logic [31:0]      val;
    logic [7:0]       tsum;
    logic             tx_valid;
    logic [7:0]       tx_data;
    logic [7:0]       param_idx;
    ccd_run_t         run;
    logic [1:0]       cal_sel;
    logic [31:0]      cal_val;
    logic [3:0]       cur_std;
    logic [15:0][7:0] ports;
    logic [3:0]       std_num;
    logic [7:0]       std_bal;
    logic [7:0]       std_gas;
    logic [1:0]       std_unit;
    logic [31:0]      std_conc;
    logic [7:0]       ctrl_id;
    logic             flash_busy;
    logic             other_busy;
    logic [3:0]       port_sel;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [2:0]       man_sync;
    logic [2:0]       din_sync;
    logic             trig_acc;
    logic             run_start;
    logic             purge_start;
    logic             purge_stop;
  } ccd_regs_t;

  localparam ccd_regs_t REGS_RST = '{
    st: ST_STX, ctrl_id: RST_NODE_ID,
    run: '{run_mode: RUN_IDLE, purge_mode: PURGE_OFF, default: '0},
    default: '0};
endpackage

// ### ccd_top.sv
// Framed command decoder with APB registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Error reply: command 0, bytes 0 and code
// - Error numbers 0 to 7 as listed
// - Command 1 reads 1 to 32 indexes
// - Read reply: index and float each
// - Command 4 with key 85 sets cal mode
// - Selectors map to four modes
// - Command 18 stores a value for selector 0 to 3
// - Command 19 dispatches on sub-command byte
// - Gas indexes 1 to 28
// - Unit indexes 0 to 3
// - Port indexes 1 to 10
// - Floats are four bytes, high byte first
// - Sub 1 sets run mode, function if needed
// - Stop blocks triggers, idle accepts them
// - Sub 2 purge operations 0 to 5
// - Purge time only when timed, zero disables
// - On-change purges on new standard
// - Sub 3 binds port to gas or standard
// - Sub 4 defines a standard
// - Frame STX id cmd ETX len msg sum EOT
// - Checksum XOR of id, cmd, len, msg
// - Requests up to 32 bytes, replies 160
module ccd_top
  import ccd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  output logic      [7:0]  param_idx,
  input  wire logic [31:0] param_value,
  input  wire logic        manual_trigger,
  input  wire logic        digital_input_trigger,
  output logic             trigger_accept,
  input  wire logic        point_start,
  input  wire logic [3:0]  point_std,
  output ccd_run_t         run_status,
  output logic             run_start,
  output logic             purge_start,
  output logic             purge_stop
);

  ccd_regs_t r_reg;
  ccd_regs_t r_next;

  // All decode and sequencing
  always_comb begin
    logic [7:0]  code;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [31:0] fv;
    logic [1:0]  cm;
    logic        sel_ok;
    logic        timed;
    logic        std_len;
    logic        hs;
    logic        setup;
    logic        wr;
    logic        hit;
    logic [31:0] rdv;
    r_next = r_reg;
    code = ERR_NONE;
    b0 = r_reg.msg[0];
    b1 = r_reg.msg[1];
    b2 = r_reg.msg[2];
    fv = {r_reg.msg[1], r_reg.msg[2], r_reg.msg[3], r_reg.msg[4]};
    cm = CAL_MEASURE;
    sel_ok = 1'b1;
    timed = (b1 == {5'h00, PURGE_TIMED});
    std_len = (r_reg.len >= STD_LEN_MIN) && (r_reg.len <= STD_LEN_MAX)
      && (8'((r_reg.len - STD_LEN_MIN) % STD_STEP) == 8'h00);
    hs = r_reg.tx_valid & tx_ready;
    setup = psel & ~penable;
    wr = psel & penable & r_reg.pready & pwrite;
    hit = 1'b1;
    rdv = 32'h00000000;
    r_next.run_start = 1'b0;
    r_next.purge_start = 1'b0;
    r_next.purge_stop = 1'b0;

    // Selector to cal mode
    if (fv == SEL_MEASURE) cm = CAL_MEASURE;
    else if (fv == SEL_CYCLE) cm = CAL_CYCLE;
    else if (fv == SEL_ZERO) cm = CAL_ZERO;
    else if (fv == SEL_SPAN) cm = CAL_SPAN;
    else sel_ok = 1'b0;

    // Request checks; first failure wins
    if (!r_reg.sum_ok) code = ERR_CSUM;
    else if (r_reg.len > REQ_LEN_MAX) code = ERR_LEN;
    else if (r_reg.other_busy) code = ERR_OTHER;
    else if (r_reg.cmd == CMD_READ) begin
      if (r_reg.len == 8'h00) code = ERR_LEN;
      else if (r_reg.flash_busy) code = ERR_FLASH;
    end else if (r_reg.cmd == CMD_CALMODE) begin
      if (r_reg.len != LEN_FLOAT) code = ERR_LEN;
      else if (b0 != CALMODE_KEY || !sel_ok) code = ERR_PARAM;
    end else if (r_reg.cmd == CMD_CALSET) begin
      if (r_reg.len != LEN_FLOAT) code = ERR_LEN;
      else if (b0 > CALSEL_MAX) code = ERR_PARAM;
    end else if (r_reg.cmd == CMD_CALIB) begin
      if (b0 == SUB_MODE) begin
        if (b1 > {6'h00, RUN_SEQ}) code = ERR_PARAM;
        else if (r_reg.len != (b1[1] ? LEN_LONG : LEN_SHORT))
          code = ERR_LEN;
        else if (b1 == {6'h00, RUN_POINT} && b2 > POINT_MAX)
          code = ERR_PARAM;
        else if (b1 == {6'h00, RUN_SEQ} && (b2 == 8'h00 || b2 > SEQ_MAX))
          code = ERR_PARAM;
      end else if (b0 == SUB_PURGE) begin
        if (b1 > {5'h00, PURGE_START}) code = ERR_PARAM;
        else if (r_reg.len != (timed ? LEN_LONG : LEN_SHORT))
          code = ERR_LEN;
        else if (timed && b2 > PURGE_TIME_MAX) code = ERR_PARAM;
      end else if (b0 == SUB_PORT) begin
        if (r_reg.len != LEN_LONG) code = ERR_LEN;
        else if (b1 == 8'h00 || b1 > PORT_MAX) code = ERR_PARAM;
        else if (b2 == 8'h00 || b2 > (b1 < PORT_SRC ? GAS_MAX : STD_MAX))
          code = ERR_PARAM;
      end else if (b0 == SUB_STD) begin
        if (!std_len) code = ERR_LEN;
        else if (b1 == 8'h00 || b1 > STD_MAX
          || r_reg.msg[POS_DAY] == 8'h00 || r_reg.msg[POS_DAY] > DAY_MAX
          || r_reg.msg[POS_MONTH] == 8'h00
          || r_reg.msg[POS_MONTH] > MONTH_MAX
          || r_reg.msg[POS_YEAR] > YEAR_MAX
          || r_reg.msg[POS_BAL] == 8'h00 || r_reg.msg[POS_BAL] > GAS_MAX
          || r_reg.msg[POS_GAS] == 8'h00 || r_reg.msg[POS_GAS] > GAS_MAX
          || r_reg.msg[POS_UNIT] > UNIT_MAX)
          code = ERR_PARAM;
      end else code = ERR_UNSUP;
    end else code = ERR_UNSUP;

    // Link state machine
    if (hs && r_reg.st inside {TX_ID, TX_CMD, TX_LEN, TX_MSG})
      r_next.tsum = r_reg.tsum ^ r_reg.tx_data;
    unique case (r_reg.st)
      ST_STX: if (rx_valid && rx_data == BYTE_STX) begin
        r_next.st = ST_ID;
      end
      ST_ID: if (rx_valid) begin
        r_next.id_ok = (rx_data == r_reg.ctrl_id);
        r_next.sum = rx_data;
        r_next.st = ST_CMD;
      end
      ST_CMD: if (rx_valid) begin
        r_next.cmd = rx_data;
        r_next.sum = r_reg.sum ^ rx_data;
        r_next.st = ST_ETX;
      end
      ST_ETX: if (rx_valid) begin
        r_next.st = (rx_data == BYTE_ETX) ? ST_LEN : ST_STX;
      end
      ST_LEN: if (rx_valid) begin
        r_next.len = rx_data;
        r_next.sum = r_reg.sum ^ rx_data;
        r_next.cnt = 8'h00;
        r_next.st = (rx_data == 8'h00) ? ST_SUM : ST_MSG;
      end
      ST_MSG: if (rx_valid) begin
        // Overflow bytes counted, not stored
        if (r_reg.cnt < REQ_LEN_MAX) r_next.msg[r_reg.cnt[4:0]] = rx_data;
        r_next.sum = r_reg.sum ^ rx_data;
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt + 8'h01 == r_reg.len) r_next.st = ST_SUM;
      end
      ST_SUM: if (rx_valid) begin
        r_next.sum_ok = (rx_data == r_reg.sum);
        r_next.st = ST_EOT;
      end
      ST_EOT: if (rx_valid) begin
        // Foreign or badly closed frames dropped
        r_next.st = (rx_data == BYTE_EOT && r_reg.id_ok) ? ST_EXEC : ST_STX;
      end
      ST_EXEC: begin
        r_next.st = TX_STX;
        r_next.tx_valid = 1'b1;
        r_next.tx_data = BYTE_STX;
        r_next.tsum = 8'h00;
        r_next.rsp_cmd = r_reg.cmd;
        r_next.rsp_len = 8'h00;
        r_next.rd = 1'b0;
        r_next.err_code = code;
        if (code != ERR_NONE) begin
          r_next.rsp_cmd = CMD_ERROR;
          r_next.rsp_len = LEN_ERR;
        end else if (r_reg.cmd == CMD_READ) begin
          r_next.rd = 1'b1;
          r_next.rsp_len = 8'(r_reg.len * READ_BYTES);
        end else if (r_reg.cmd == CMD_CALMODE) begin
          r_next.run.cal_mode = cm;
        end else if (r_reg.cmd == CMD_CALSET) begin
          r_next.cal_sel = b0[1:0];
          r_next.cal_val = fv;
        end else if (b0 == SUB_MODE) begin
          r_next.run.run_mode = b1[1:0];
          r_next.run.func = b1[1] ? b2 : 8'h00;
          r_next.run_start = b1[1];
          r_next.purge_stop = (b1[1:0] == RUN_STOP);
        end else if (b0 == SUB_PURGE) begin
          r_next.purge_stop = (b1[2:0] == PURGE_STOP);
          r_next.purge_start = r_next.purge_start
            | (b1[2:0] == PURGE_NOW);
          if (timed) begin
            r_next.run.purge_time = b2;
            r_next.run.purge_mode = (b2 == 8'h00) ? PURGE_OFF
              : PURGE_TIMED;
          end else if (b1[2:0] >= PURGE_OFF) begin
            r_next.run.purge_mode = b1[2:0];
          end
        end else if (b0 == SUB_PORT) begin
          r_next.ports[b1[3:0]] = b2;
        end else begin
          r_next.std_num = b1[3:0];
          r_next.std_bal = r_reg.msg[POS_BAL];
          r_next.std_gas = r_reg.msg[POS_GAS];
          r_next.std_unit = r_reg.msg[POS_UNIT][1:0];
          r_next.std_conc = {r_reg.msg[POS_CONC],
            r_reg.msg[POS_CONC + 5'h01], r_reg.msg[POS_CONC + 5'h02],
            r_reg.msg[POS_CONC + 5'h03]};
        end
      end
      TX_STX: if (hs) begin
        r_next.tx_data = r_reg.ctrl_id;
        r_next.st = TX_ID;
      end
      TX_ID: if (hs) begin
        r_next.tx_data = r_reg.rsp_cmd;
        r_next.st = TX_CMD;
      end
      TX_CMD: if (hs) begin
        r_next.tx_data = BYTE_ETX;
        r_next.st = TX_ETX;
      end
      TX_ETX: if (hs) begin
        r_next.tx_data = r_reg.rsp_len;
        r_next.st = TX_LEN;
      end
      TX_LEN: if (hs) begin
        r_next.cnt = 8'h00;
        r_next.k = 5'h00;
        r_next.sub = 3'h0;
        r_next.param_idx = r_reg.msg[0];
        if (r_reg.rsp_len == 8'h00) begin
          r_next.tx_data = r_reg.tsum ^ r_reg.tx_data;
          r_next.st = TX_SUM;
        end else begin
          // Error replies open with a zero byte
          r_next.tx_data = r_reg.rd ? r_reg.msg[0] : 8'h00;
          r_next.st = TX_MSG;
        end
      end
      TX_MSG: if (hs) begin
        r_next.cnt = r_reg.cnt + 8'h01;
        if (r_reg.cnt + 8'h01 == r_reg.rsp_len) begin
          r_next.tx_data = r_reg.tsum ^ r_reg.tx_data;
          r_next.st = TX_SUM;
        end else if (!r_reg.rd) begin
          r_next.tx_data = r_reg.err_code;
        end else if (r_reg.sub == 3'h4) begin
          // Next index byte starts its lookup
          r_next.k = r_reg.k + 5'h01;
          r_next.sub = 3'h0;
          r_next.tx_data = r_reg.msg[r_reg.k + 5'h01];
          r_next.param_idx = r_reg.msg[r_reg.k + 5'h01];
        end else if (r_reg.sub == 3'h0) begin
          // Value caught once so it cannot tear
          r_next.val = {param_value[23:0], 8'h00};
          r_next.tx_data = param_value[31:24];
          r_next.sub = 3'h1;
        end else begin
          r_next.val = {r_reg.val[23:0], 8'h00};
          r_next.tx_data = r_reg.val[31:24];
          r_next.sub = r_reg.sub + 3'h1;
        end
      end
      TX_SUM: if (hs) begin
        r_next.tx_data = BYTE_EOT;
        r_next.st = TX_EOT;
      end
      TX_EOT: if (hs) begin
        r_next.tx_valid = 1'b0;
        r_next.st = ST_STX;
      end
    endcase

    // Trigger pins: two-stage sync, then edge
    r_next.man_sync = {r_reg.man_sync[1:0], manual_trigger};
    r_next.din_sync = {r_reg.din_sync[1:0], digital_input_trigger};
    r_next.trig_acc = ((r_reg.man_sync[1] & ~r_reg.man_sync[2])
      | (r_reg.din_sync[1] & ~r_reg.din_sync[2]))
      & (r_reg.run.run_mode != RUN_STOP);

    // Point start: track standard, maybe purge
    if (point_start && r_reg.run.run_mode != RUN_STOP) begin
      r_next.cur_std = point_std;
      if ((r_reg.run.purge_mode == PURGE_CHANGE
        && point_std != r_reg.cur_std)
        || r_reg.run.purge_mode == PURGE_START)
        r_next.purge_start = 1'b1;
    end

    // APB read mux; unmapped offsets error
    unique case (paddr)
      REG_CTRL:
        rdv = {22'h000000, r_reg.other_busy, r_reg.flash_busy,
          r_reg.ctrl_id};
      REG_STATUS:  rdv = {9'h000, r_reg.run};
      REG_CALVAL:  rdv = r_reg.cal_val;
      REG_CALSEL:  rdv = {30'h00000000, r_reg.cal_sel};
      REG_STD:
        rdv = {6'h00, r_reg.std_unit, r_reg.std_gas, r_reg.std_bal,
          r_reg.cur_std, r_reg.std_num};
      REG_STDCONC: rdv = r_reg.std_conc;
      REG_PORTSEL: rdv = {28'h0000000, r_reg.port_sel};
      REG_PORTATT: rdv = {24'h000000, r_reg.ports[r_reg.port_sel]};
      default:     hit = 1'b0;
    endcase
    // Answer in setup: one-cycle access phase
    r_next.pready = setup;
    r_next.pslverr = setup & ~hit;
    r_next.prdata = setup ? rdv : 32'h00000000;
    if (wr && paddr == REG_CTRL) begin
      r_next.ctrl_id = pwdata[7:0];
      r_next.flash_busy = pwdata[8];
      r_next.other_busy = pwdata[9];
    end
    if (wr && paddr == REG_PORTSEL) r_next.port_sel = pwdata[3:0];
  end

  // Single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Registered outputs
  assign prdata         = r_reg.prdata;
  assign pready         = r_reg.pready;
  assign pslverr        = r_reg.pslverr;
  assign tx_valid       = r_reg.tx_valid;
  assign tx_data        = r_reg.tx_data;
  assign param_idx      = r_reg.param_idx;
  assign trigger_accept = r_reg.trig_acc;
  assign run_status     = r_reg.run;
  assign run_start      = r_reg.run_start;
  assign purge_start    = r_reg.purge_start;
  assign purge_stop     = r_reg.purge_stop;

endmodule // ccd_top
`default_nettype wire

// ### ccd_properties.sv
// Port-level checks of the decoder
`timescale 1ns/1ps
`default_nettype none
module ccd_properties
  import ccd_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic       trigger_accept,
  input wire logic       point_start,
  input wire ccd_run_t   run_status,
  input wire logic       run_start,
  input wire logic       purge_start,
  input wire logic       purge_stop
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Handshakes
  ans_next_a: assert property (psel && !penable |=> pready)
    else $error("pready late");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx hold");
  // Stop, run-start and start-purge behaviour
  stop_trig_a: assert property (
    trigger_accept |-> $past(run_status.run_mode) != RUN_STOP)
    else $error("stop trig");
  stop_purge_a: assert property (
    $rose(run_status.run_mode == RUN_STOP)
    |-> purge_stop || $past(purge_stop))
    else $error("stop purge");
  run_go_a: assert property (
    run_start |-> ##[0:1] run_status.run_mode[1])
    else $error("run start");
  on_start_a: assert property (
    point_start && run_status.purge_mode == PURGE_START &&
    run_status.run_mode != RUN_STOP |-> ##[0:1] purge_start)
    else $error("start purge");
  // Stored field ranges
  seq_range_a: assert property (
    run_status.run_mode == RUN_SEQ |-> run_status.func inside {[1:16]})
    else $error("seq range");
  ptime_a: assert property (
    run_status.purge_mode == PURGE_TIMED
    |-> run_status.purge_time inside {[1:15]})
    else $error("purge time");
  cover property (run_start);
  cover property (purge_start);
  cover property (trigger_accept);
endmodule // ccd_properties
bind ccd_top ccd_properties ccd_properties_i (.pclk, .presetn, .psel,
  .penable, .pready, .tx_valid, .tx_data, .tx_ready, .trigger_accept,
  .point_start, .run_status, .run_start, .purge_start, .purge_stop);
`default_nettype wire

// ### ccd_host.sv
// Host model: reply sink, parameter source
`timescale 1ns/1ps
`default_nettype none
module ccd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  param_idx,
  output logic             tx_ready,
  output logic      [31:0] param_value
);
  // Value from index, no latency
  assign param_value = {param_idx, ~param_idx,
                        param_idx ^ 8'hA5, 8'h3C};
  // Random stalls test byte hold
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) tx_ready <= 1'b0;
    else tx_ready <= ($urandom % 4) != 0;
endmodule // ccd_host
`default_nettype wire

// ### ccd_top_tb.sv
// Self-checking bench for the decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module ccd_top_tb;
  import ccd_pkg::*;
  typedef logic [7:0] ccd_bq_t[$];
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        rx_valid = 0, manual_trigger = 0, digital_input_trigger = 0;
  logic        point_start = 0, tx_ready, tx_valid, pready, pslverr, er;
  logic        trigger_accept, run_start, purge_start, purge_stop;
  logic [7:0]  paddr = 0, rx_data = 0, tx_data, param_idx, id, x;
  logic [3:0]  point_std = 0;
  logic [31:0] pwdata = 0, prdata, param_value, rd, v;
  logic [31:0] sel [4] = '{32'h0, 32'h3F800000, 32'h40000000, 32'h40400000};
  ccd_run_t    run_status;
  ccd_bq_t     eq, q;
  int          n_errors = 0, checks = 0, i, c;
  ccd_top ccd_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready, .param_idx, .param_value, .manual_trigger,
    .digital_input_trigger, .trigger_accept, .point_start, .point_std,
    .run_status, .run_start, .purge_start, .purge_stop);
  ccd_host ccd_host_i (.pclk, .presetn, .param_idx, .tx_ready, .param_value);
  always #5 pclk = ~pclk;
  // Score each accepted reply byte
  always @(posedge pclk) if (tx_valid && tx_ready) begin
    x = eq.size() != 0 ? eq.pop_front() : 8'hXX;
    `CHK(tx_data, x)
  end
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    n_errors++;
    tally_and_finish;
  end
  // One APB transfer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Idle line shows the inverse
  task automatic put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge pclk) rx_valid <= 1'b0;
    rx_data <= ~b;
    @(posedge pclk);
  endtask
  function automatic ccd_bq_t frame(input logic [7:0] cm, input ccd_bq_t m);
    logic [7:0] s;
    s = id ^ cm ^ 8'(m.size());
    foreach (m[k]) s ^= m[k];
    return {BYTE_STX, id, cm, BYTE_ETX, 8'(m.size()), m, s,
            BYTE_EOT};
  endfunction
  function automatic ccd_bq_t rdq(input ccd_bq_t m);
    ccd_bq_t r;
    foreach (m[k]) r = {r, m[k], m[k], ~m[k], m[k] ^ 8'hA5, 8'h3C};
    return r;
  endfunction
  // Send, queue reply (FF: none), drain
  task automatic xact(input logic [7:0] cm, input ccd_bq_t m, r,
                      input logic [7:0] rc, input bit bad);
    ccd_bq_t f;
    int k;
    f = frame(cm, m);
    f[f.size() - 2] ^= {7'h0, bad};
    if (rc != 8'hFF) eq = {eq, frame(rc, r)};
    foreach (f[j]) put(f[j]);
    for (k = 0; k < 3000 && eq.size() != 0; k++) @(posedge pclk);
    repeat (12) @(posedge pclk);
    `CHK(eq.size(), 0)
  endtask
  task automatic ok(input logic [7:0] cm, input ccd_bq_t m);
    xact(cm, m, '{}, cm, 0);
  endtask
  task automatic err(input logic [7:0] cm, input ccd_bq_t m,
                     input logic [7:0] e, input bit bad = 0);
    xact(cm, m, '{8'h00, e}, CMD_ERROR, bad);
  endtask
  task automatic watch(ref logic s);
    c = 0;
    repeat (10) begin
      @(posedge pclk);
      c += int'(s === 1'b1);
    end
  endtask
  initial begin
    c = $urandom(32'h75F8);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, node id, bad offset
    apb(0, REG_STATUS, 0);
    `CHK(rd, {9'h0, RUN_IDLE, 8'h00, CAL_MEASURE, PURGE_OFF, 8'h00})
    id = 8'($urandom_range(127, 1));
    apb(1, REG_CTRL, {24'h0, id});
    apb(0, REG_CTRL, 0);
    `CHK(rd[7:0], id)
    apb(0, 8'h40, 0);
    `CHK({er, rd}, 33'h100000000)
    // Longest read, overlong, bad sum, foreign id
    repeat (32) q.push_back(8'($urandom));
    xact(CMD_READ, q, rdq(q), CMD_READ, 0);
    q.push_back(8'h01);
    err(CMD_READ, q, ERR_LEN);
    err(CMD_READ, '{8'h01}, ERR_CSUM, 1);
    err(8'h07, '{}, ERR_UNSUP);
    id ^= 8'h80;
    xact(CMD_READ, '{8'h01}, '{}, 8'hFF, 0);
    id ^= 8'h80;
    // All cal modes, wrong key
    for (i = 0; i < 4; i++) begin
      ok(CMD_CALMODE, '{CALMODE_KEY, sel[i][31:24], sel[i][23:16],
                        sel[i][15:8], sel[i][7:0]});
      `CHK(run_status.cal_mode, 2'(i))
    end
    err(CMD_CALMODE, '{8'h54, 8'h00, 8'h00, 8'h00, 8'h00},
        ERR_PARAM);
    v = $urandom;
    ok(CMD_CALSET, '{8'h02, v[31:24], v[23:16], v[15:8], v[7:0]});
    apb(0, REG_CALVAL, 0);
    `CHK(rd, v)
    apb(0, REG_CALSEL, 0);
    `CHK(rd[1:0], 2'h2)
    // Run mode limits; stop blocks triggers
    ok(CMD_CALIB, '{SUB_MODE, 8'h02, 8'h20});
    ok(CMD_CALIB, '{SUB_MODE, 8'h03, 8'h10});
    `CHK({run_status.run_mode, run_status.func}, 10'h310)
    err(CMD_CALIB, '{SUB_MODE, 8'h03, 8'h11}, ERR_PARAM);
    ok(CMD_CALIB, '{SUB_MODE, 8'h00});
    {digital_input_trigger, manual_trigger} <= 2'b01;
    watch(trigger_accept);
    `CHK(c != 0, 1'b0)
    {digital_input_trigger, manual_trigger} <= 2'b00;
    ok(CMD_CALIB, '{SUB_MODE, 8'h01});
    {digital_input_trigger, manual_trigger} <= 2'b10;
    watch(trigger_accept);
    `CHK(c != 0, 1'b1)
    {digital_input_trigger, manual_trigger} <= 2'b00;
    // Purge time limits, every operation
    ok(CMD_CALIB, '{SUB_PURGE, 8'h02, 8'h00});
    `CHK(run_status.purge_mode, 3'h3)
    err(CMD_CALIB, '{SUB_PURGE, 8'h02, 8'h10}, ERR_PARAM);
    err(CMD_CALIB, '{SUB_PURGE, 8'h06}, ERR_PARAM);
    for (i = 0; i < 6; i++) begin
      q = '{SUB_PURGE, 8'(i)};
      if (i == 2) q.push_back(8'h0F);
      ok(CMD_CALIB, q);
      if (i == 2) `CHK(run_status[10:0], 11'h20F)
    end
    point_std <= 4'h3;
    point_start <= 1'b1;
    @(posedge pclk) point_start <= 1'b0;
    watch(purge_start);
    `CHK(c, 1)
    // Port bindings at limits
    ok(CMD_CALIB, '{SUB_PORT, 8'h0A, 8'h0A});
    ok(CMD_CALIB, '{SUB_PORT, 8'h02, 8'h1C});
    apb(1, REG_PORTSEL, 32'h0A);
    apb(0, REG_PORTATT, 0);
    `CHK(rd, 32'h0A)
    err(CMD_CALIB, '{SUB_PORT, 8'h0B, 8'h01}, ERR_PARAM);
    err(CMD_CALIB, '{SUB_PORT, 8'h01, 8'h1D}, ERR_PARAM);
    err(CMD_CALIB, '{8'h09}, ERR_UNSUP);
    // Standard ten, then a bad unit
    q = '{SUB_STD, 8'h0A};
    repeat (12) q.push_back(8'h41);
    q = {q, 8'h1F, 8'h0C, 8'h3F, 8'h1C, 8'h1B, 8'h03,
         8'h42, 8'hC8, 8'h00, 8'h00};
    ok(CMD_CALIB, q);
    apb(0, REG_STD, 0);
    `CHK({rd[25:8], rd[3:0]}, {2'h3, 8'h1B, 8'h1C, 4'hA})
    apb(0, REG_STDCONC, 0);
    `CHK(rd, 32'h42C80000)
    q[19] = 8'h04;
    err(CMD_CALIB, q, ERR_PARAM);
    tally_and_finish;
  end
endmodule // ccd_top_tb
`default_nettype wire
